// File: core/xped_top.sv
// Operation
// - first can enable low blocks that controller and frees its two pins.
// - first can window goes external only when both can enables are low.
// - second can enable low blocks that controller and frees its pins.
// - second can window goes external only when both can enables are low.
// - small ram enable selects internal 2K ram or external for its window.
// - large ram enable selects internal 8K ram or external for its window.
// - calendar disabled goes external only when both can enables are low.
// - with both cans off the whole can range uses the external interface.
// - enable register resets to 05h.
// - enable register is frozen once the global enable is set.
// - mode_a mode forces all enables on.
// - calendar disabled means oscillator off in power-down.
// - calendar enabled lets the oscillator-off bit choose.
//
// The Wishbone slave port was decided locally.
module xped_top
  import xped_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // mode inputs
  input wire logic mode_a,
  input wire logic power_down,
  // cpu access to be routed
  input wire logic [23:0] cpu_addr,
  output xped_tgt_t cpu_target,
  output logic cpu_to_ext,
  // effective enables to the peripherals
  output logic [4:0] periph_enable,
  output logic first_can_pins_gpio,
  output logic second_can_pins_gpio,
  output logic osc_stop
);
  logic rst_s1_r, rst_n_r;
  logic [4:0] en_r, en_nxt;
  logic glob_r, glob_nxt;
  logic osc_off_r, osc_off_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic [31:0] dat_r, dat_nxt;
  xped_tgt_t tgt;
  logic req, hit_en, hit_sys, hit_cal, hit_st;

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // effective enables, mode_a overrides the register
  assign periph_enable = mode_a ? XPED_EN_ALL : en_r;
  assign first_can_pins_gpio = ~periph_enable[XPED_FIRST_CAN_BIT];
  assign second_can_pins_gpio = ~periph_enable[XPED_SECOND_CAN_BIT];

  // oscillator control in power-down
  always_comb begin
    if (!periph_enable[XPED_CAL_BIT]) osc_stop = power_down;
    else osc_stop = power_down & osc_off_r;
  end

  xped_decode u_dec (
    .en(periph_enable),
    .addr(cpu_addr),
    .tgt(tgt)
  );
  assign cpu_target = tgt;
  assign cpu_to_ext = (tgt == XPED_TGT_EXT);

  // register decode
  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    hit_en = (wb_adr_i == XPED_PERIPH_EN_OFS);
    hit_sys = (wb_adr_i == XPED_SYS_CFG_OFS);
    hit_cal = (wb_adr_i == XPED_CAL_CTRL_OFS);
    hit_st = (wb_adr_i == XPED_STATUS_OFS);
  end

  // next register values; byte lane 0 carries all control bits
  always_comb begin
    en_nxt = en_r;
    glob_nxt = glob_r;
    osc_off_nxt = osc_off_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    dat_nxt = dat_r;
    if (req) begin
      ack_nxt = hit_en | hit_sys | hit_cal | hit_st;
      err_nxt = ~(hit_en | hit_sys | hit_cal | hit_st);
      if (wb_we_i && wb_sel_i[0]) begin
        if (hit_en && !glob_r) begin
          en_nxt = wb_dat_i[4:0];
        end // locked: keep value
        if (hit_sys) begin
          glob_nxt = glob_r | wb_dat_i[XPED_GLOBAL_EN_BIT];
        end
        if (hit_cal) begin
          osc_off_nxt = wb_dat_i[XPED_OSC_OFF_BIT];
        end
      end
      dat_nxt = 32'h0000_0000;
      if (hit_en) dat_nxt = {27'h0, en_r};
      if (hit_sys) dat_nxt = {31'h0, glob_r};
      if (hit_cal) dat_nxt = {31'h0, osc_off_r};
      if (hit_st) dat_nxt = {26'h0, osc_stop, periph_enable};
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      en_r <= XPED_EN_RESET;
      glob_r <= 1'b0;
      osc_off_r <= 1'b0;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      en_r <= en_nxt;
      glob_r <= glob_nxt;
      osc_off_r <= osc_off_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = dat_r;
endmodule : xped_top

// File: core/xped_pkg.sv
package xped_pkg;
  // register map, byte addresses on the wishbone side
  localparam logic [15:0] XPED_PERIPH_EN_OFS = 16'hf024;
  localparam logic [15:0] XPED_SYS_CFG_OFS = 16'hf028;
  localparam logic [15:0] XPED_CAL_CTRL_OFS = 16'hf02c;
  localparam logic [15:0] XPED_STATUS_OFS = 16'hf030;
  // enable field positions
  localparam int XPED_FIRST_CAN_BIT = 0;
  localparam int XPED_SECOND_CAN_BIT = 1;
  localparam int XPED_SMALL_RAM_BIT = 2;
  localparam int XPED_LARGE_RAM_BIT = 3;
  localparam int XPED_CAL_BIT = 4;
  localparam int XPED_EN_W = 5;
  localparam logic [4:0] XPED_EN_RESET = 5'h05;
  localparam logic [4:0] XPED_EN_ALL = 5'h1f;
  // other control fields
  localparam int XPED_GLOBAL_EN_BIT = 0;
  localparam int XPED_OSC_OFF_BIT = 0;
  // cpu address windows, 24 bit
  localparam logic [23:0] XPED_LRAM_LO = 24'h00c000;
  localparam logic [23:0] XPED_LRAM_HI = 24'h00dfff;
  localparam logic [23:0] XPED_SRAM_LO = 24'h00e000;
  localparam logic [23:0] XPED_SRAM_HI = 24'h00e7ff;
  localparam logic [23:0] XPED_CAL_LO = 24'h00ec00;
  localparam logic [23:0] XPED_CAL_HI = 24'h00ecff;
  localparam logic [23:0] XPED_CAN2_LO = 24'h00ee00;
  localparam logic [23:0] XPED_CAN2_HI = 24'h00eeff;
  localparam logic [23:0] XPED_CAN1_LO = 24'h00ef00;
  localparam logic [23:0] XPED_CAN1_HI = 24'h00efff;
  // decoded target of a cpu access
  typedef enum logic [2:0] {
    XPED_TGT_NONE,
    XPED_TGT_EXT,
    XPED_TGT_CAN1,
    XPED_TGT_CAN2,
    XPED_TGT_SRAM,
    XPED_TGT_LRAM,
    XPED_TGT_CAL,
    XPED_TGT_BLOCKED
  } xped_tgt_t;
endpackage : xped_pkg

// File: core/xped_decode.sv
// combinational address decoder for one cpu access
module xped_decode
  import xped_pkg::*;
(
  // effective enables and access
  input wire logic [4:0] en,
  input wire logic [23:0] addr,
  // result
  output xped_tgt_t tgt
);
  logic any_can;

  // routing decision per window
  always_comb begin
    any_can = en[XPED_FIRST_CAN_BIT] | en[XPED_SECOND_CAN_BIT];
    tgt = XPED_TGT_NONE;
    if (addr >= XPED_CAN1_LO && addr <= XPED_CAN1_HI) begin
      if (en[XPED_FIRST_CAN_BIT]) tgt = XPED_TGT_CAN1;
      else if (any_can) tgt = XPED_TGT_BLOCKED;
      else tgt = XPED_TGT_EXT;
    end else if (addr >= XPED_CAN2_LO && addr <= XPED_CAN2_HI) begin
      if (en[XPED_SECOND_CAN_BIT]) tgt = XPED_TGT_CAN2;
      else if (any_can) tgt = XPED_TGT_BLOCKED;
      else tgt = XPED_TGT_EXT;
    end else if (addr >= XPED_CAL_LO && addr <= XPED_CAL_HI) begin
      if (en[XPED_CAL_BIT]) tgt = XPED_TGT_CAL;
      else if (any_can) tgt = XPED_TGT_BLOCKED;
      else tgt = XPED_TGT_EXT;
    end else if (addr >= XPED_SRAM_LO && addr <= XPED_SRAM_HI) begin
      tgt = en[XPED_SMALL_RAM_BIT] ? XPED_TGT_SRAM : XPED_TGT_EXT;
    end else if (addr >= XPED_LRAM_LO && addr <= XPED_LRAM_HI) begin
      tgt = en[XPED_LARGE_RAM_BIT] ? XPED_TGT_LRAM : XPED_TGT_EXT;
    end
  end
endmodule : xped_decode

// File: tb/xped_top_assertions.sv
module xped_chk
  import xped_pkg::*;
(
  // clock, reset and bus answer
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // modes, routing and enables
  input wire logic mode_a,
  input wire logic power_down,
  input wire logic [23:0] cpu_addr,
  input wire xped_tgt_t cpu_target,
  input wire logic cpu_to_ext,
  input wire logic [4:0] periph_enable,
  input wire logic first_can_pins_gpio,
  input wire logic second_can_pins_gpio,
  input wire logic osc_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // a request gets exactly one single-cycle answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_answer;
    (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endsequence
  a_bus_answer: assert property (s_req |=> s_answer)
    else $error("bus answer missing or too long");
  a_emu_all_on: assert property (mode_a |-> periph_enable == 5'h1f)
    else $error("mode_a did not force enables");
  a_can1_pins: assert property (first_can_pins_gpio == !periph_enable[0])
    else $error("first can pins wrong");
  a_can2_pins: assert property (second_can_pins_gpio == !periph_enable[1])
    else $error("second can pins wrong");
  a_osc_cal_off: assert property (power_down && !periph_enable[4] |-> osc_stop)
    else $error("oscillator kept running");
  a_osc_awake: assert property (!power_down |-> !osc_stop)
    else $error("oscillator stopped while awake");
  a_small_ram: assert property (cpu_addr inside {[XPED_SRAM_LO:XPED_SRAM_HI]}
    |-> cpu_target == (periph_enable[2] ? XPED_TGT_SRAM : XPED_TGT_EXT))
    else $error("small ram routing");
  a_large_ram: assert property (cpu_addr inside {[XPED_LRAM_LO:XPED_LRAM_HI]}
    |-> cpu_target == (periph_enable[3] ? XPED_TGT_LRAM : XPED_TGT_EXT))
    else $error("large ram routing");
  a_cal_route: assert property (cpu_addr inside {[XPED_CAL_LO:XPED_CAL_HI]}
    |-> cpu_target == (periph_enable[4] ? XPED_TGT_CAL :
    (periph_enable[1:0] != 2'h0) ? XPED_TGT_BLOCKED : XPED_TGT_EXT))
    else $error("calendar window routing");
  a_can_ext: assert property (cpu_addr inside {[XPED_CAN2_LO:XPED_CAN1_HI]}
    && periph_enable[1:0] == 2'h0 |-> cpu_to_ext)
    else $error("can range not external");
endmodule : xped_chk
bind xped_top xped_chk u_xped_chk (.*);

// File: tb/xped_cpu_model.sv
module xped_cpu_model (
  // next address asked for, address on the cpu bus
  input wire logic clk,
  input wire logic [23:0] next_addr,
  output logic [23:0] cpu_addr = 24'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // the cpu launches a new access just after each edge
  always @(posedge clk) cpu_addr <= next_addr;
endmodule : xped_cpu_model

// File: tb/test_xped_top.sv
module test_xped_top
  import xped_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, cyc = 0, we = 0, mode_a = 0, pd = 0, werr;
  logic [15:0] adr = 16'h0;
  logic [31:0] dat = 32'h0, rd, wo, seed = 32'hd717;
  logic [23:0] nxt = 24'h0, cpu_addr;
  logic [4:0] pen, e;
  logic ack, err, ext, g1, g2, osc;
  xped_tgt_t tgt;
  int failures = 0, n_compared = 0;
  always #25 clk = ~clk;
  xped_top u_xped_top (.clk, .arst_n, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err), .mode_a,
    .power_down(pd), .cpu_addr, .cpu_target(tgt), .cpu_to_ext(ext),
    .periph_enable(pen), .first_can_pins_gpio(g1),
    .second_can_pins_gpio(g2), .osc_stop(osc));
  xped_cpu_model u_xped_cpu_model (.clk, .next_addr(nxt), .cpu_addr);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // disabled can and calendar windows go out only while both cans are off
  function automatic xped_tgt_t exp_tgt(logic [4:0] e, logic [23:0] a);
    xped_tgt_t t;
    t = (e[1:0] == 2'h0) ? XPED_TGT_EXT : XPED_TGT_BLOCKED;
    case (a[15:8]) inside
      [8'hc0:8'hdf]: return e[3] ? XPED_TGT_LRAM : XPED_TGT_EXT;
      [8'he0:8'he7]: return e[2] ? XPED_TGT_SRAM : XPED_TGT_EXT;
      8'hec: return e[4] ? XPED_TGT_CAL : t;
      8'hee: return e[1] ? XPED_TGT_CAN2 : t;
      8'hef: return e[0] ? XPED_TGT_CAN1 : t;
      default: return XPED_TGT_NONE;
    endcase
  endfunction : exp_tgt
  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // one classic cycle, held until the answer is sampled
  task automatic wb(logic w, logic [15:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(ack || err) && n < 20);
    if (!(ack || err)) begin
      failures++;
      final_report;
    end
    wo = rd;
    werr = err;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(0, XPED_PERIPH_EN_OFS, 0);
    chk("reset enables", wo, 32'h5);
    wb(1, 16'hf000, 0);
    chk("unmapped error", 32'(werr), 32'h1);
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      mode_a <= (i > 52);
      pd <= seed[8];
      nxt <= XPED_LRAM_LO + 24'(seed[31:16] % 16'h3000);
      wb(1, XPED_PERIPH_EN_OFS, seed);
      wb(1, XPED_CAL_CTRL_OFS, 32'(seed[9]));
      wb(0, XPED_PERIPH_EN_OFS, 0);
      e = mode_a ? 5'h1f : seed[4:0];
      chk("enable readback", wo, 32'(seed[4:0]));
      chk("enables", 32'({pen, g1, g2}), 32'({e, !e[0], !e[1]}));
      chk("target", 32'(tgt), 32'(exp_tgt(e, cpu_addr)));
      chk("external", 32'(ext), 32'(exp_tgt(e, cpu_addr) == XPED_TGT_EXT));
      chk("osc stop", 32'(osc), 32'(pd & (!e[4] | seed[9])));
      // status shows what the peripherals really get, mode_a included
      wb(0, XPED_STATUS_OFS, 0);
      chk("status", wo, 32'({pd & (!e[4] | seed[9]), e}));
      wb(0, XPED_CAL_CTRL_OFS, 0);
      chk("osc off readback", wo, 32'(seed[9]));
    end
    wb(1, XPED_SYS_CFG_OFS, 1);
    wb(1, XPED_PERIPH_EN_OFS, ~seed);
    wb(0, XPED_PERIPH_EN_OFS, 0);
    chk("locked enables", wo, 32'(seed[4:0]));
    // the global enable is sticky: a later zero must not unlock
    wb(1, XPED_SYS_CFG_OFS, 0);
    wb(0, XPED_SYS_CFG_OFS, 0);
    chk("global enable", wo, 32'h1);
    final_report;
  end
endmodule : test_xped_top
